/* common/aux_env_pkg.sv */
// Purpose: Constants shared by the auxiliary envelope interrupt unit
// Assumes: Serial control link carries one address byte, then data bytes
// Notes:   Register select codes are seven-bit, bit 7 of the address marks a read
package aux_env_pkg;
    localparam int          BYTE_W        = 8;
    localparam int          CNT_W         = 16;
    localparam int          NUM_FLAGS     = 6;
    localparam logic [2:0]  LAST_BIT      = 3'h7;
    // Address byte layout
    localparam int          ADDR_RD_BIT   = 7;
    localparam logic [6:0]  SEL_MASK      = 7'h01;
    localparam logic [6:0]  SEL_EQUALIZER_STATUS_ZERO   = 7'h02;
    localparam logic [6:0]  SEL_EQUALIZER_STATUS_ONE   = 7'h03;
    localparam logic [6:0]  SEL_COUNTER   = 7'h04;
    localparam logic [6:0]  SEL_SPEED     = 7'h05;
    localparam logic [6:0]  SEL_EQ_SET    = 7'h06;
    localparam logic [6:0]  SEL_TF_SET0   = 7'h07;
    // Interrupt mask fields
    localparam int          BYPASS_HI     = 7;
    localparam int          BYPASS_LO     = 6;
    localparam logic [7:0]  MASK_RESET    = 8'h00;
    localparam logic [1:0]  BYP_NONE      = 2'h0;
    localparam logic [1:0]  BYP_MARKER    = 2'h1;
    localparam logic [1:0]  BYP_ENVELOPE  = 2'h2;
    localparam logic [1:0]  BYP_BLANK     = 2'h3;
    // Flag positions, shared by mask and status byte zero
    localparam int          FLG_BLANK_UP  = 5;
    localparam int          FLG_ENV_UP    = 4;
    localparam int          FLG_ENV_DN    = 3;
    localparam int          FLG_MARK_UP   = 2;
    localparam int          FLG_MARK_DN   = 1;
    localparam int          FLG_CNT_ZERO  = 0;
    // Status byte one fields
    localparam int          ST1_PORT_IN   = 3;
    localparam int          ST1_BLANK     = 2;
    localparam int          ST1_ENV       = 1;
    localparam int          ST1_MARK      = 0;
    // Equalizer settings fields
    localparam int          EQ_DIR_BIT    = 2;
    localparam logic [1:0]  MODE_NORMAL   = 2'h0;
    localparam logic [1:0]  MODE_SEARCH   = 2'h1;
    localparam logic [7:0]  EQ_SET_RESET  = 8'h00;
    // Tape formatter settings zero fields
    localparam int          TF_PORT_OUT1  = 0;
    localparam logic [7:0]  TF_SET_RESET  = 8'h00;
    localparam logic [15:0] CNT_RESET     = 16'h0000;
    localparam logic [15:0] WORD_ZERO     = 16'h0000;
endpackage

/* design/aux_envelope_interrupt_unit.sv */
// Purpose: Interrupt, status and envelope counter logic of the auxiliary channel
// Assumes: mclk 40 MHz; link_clk is the serial control clock from the host
// Notes:   Link words cross as quasi-static data qualified by toggles
//          Both clocks run with no phase relation; the link clock stops
//          between frames, so every link-to-core handover is a toggle that the core
//          sees only after two of its own flip-flops.
//          Read data is captured into a snapshot word when the address
//          byte lands and is left alone until the next read, which is why
//          the host must leave a gap before clocking data out.
//          Detector and port levels are treated as asynchronous pins, so
//          edge events trail the pins by three mclk cycles.
//          The test bit and bank flag are same-clock levels, not synced.
//          Write-only and unknown selects read back as zero.
// How it works
// - Pulse azimuth output on channel zero/seven sync
// - Port input pin shows in status one
// - Formatter settings bit drives port output one
// - Mask register write-only, resets to zero
// - Mask: bypass, blank, envelope, marker, counter-zero
// - Bypass code selects level for interrupt pin
// - Bypass active suppresses interrupts, shows level
// - Pin low for interrupts, high-true bypassed
// - Mask bits 5-0 each enable their own source
// - Pin held low until status zero read
// - Later events recorded, re-assert after read
// - Reading status zero clears recorded flags
// - Status zero: bank flag, test, six flags
// - Status one: blank, envelope, marker live levels
// - Detector levels arrive from envelope front end
// - Envelope events honoured only in search mode
// - Envelope lag set by the detector front end
// - Counter-zero event when counter steps to zero
// - Counter moves as two bytes, low first
// - Speed register: value bits 6-2, range 1-0
// - Speed bit 7 flags invalid measurement
// - Search mode code selects auxiliary-only processing
// - Counter steps on envelope rise, direction selectable
`timescale 1ns/1ps
`default_nettype none
module aux_envelope_interrupt_unit (
    input  wire logic        mclk,                    // Master clock, 40 MHz
    input  wire logic        arst_n,                  // Asynchronous reset, active low
    input  wire logic        link_clk,                // Serial control clock from host
    input  wire logic        link_mode,               // Low: address byte, high: data
    input  wire logic        link_data_in,            // Serial data pin, input side
    output logic             link_data_out,           // Serial data pin, output side
    output logic             link_data_oe_n,          // Low while device drives data
    output logic             host_interrupt_pin,      // Interrupt or bypassed level
    input  wire logic        blank_tape_signal,       // Blank tape detector level
    input  wire logic        aux_envelope,            // One-bit auxiliary envelope
    input  wire logic        marker_level,            // Marker detector level
    input  wire logic        port_input,              // General-purpose input pin
    output logic             port_output_one,         // General-purpose output pin
    input  wire logic        tape_channel_zero,       // Sync symbol seen on channel 0
    input  wire logic        tape_channel_seven,      // Sync symbol seen on channel 7
    output logic             azimuth_check_out,       // Azimuth check pulse
    input  wire logic        coefficient_bank_switched, // New coefficients active
    input  wire logic        status_test_bit,         // Test bit for status zero
    input  wire logic        speed_invalid_flag,      // Speed measurement invalid
    input  wire logic [4:0]  speed_value,             // Measured speed value
    input  wire logic [1:0]  speed_range,             // Measured speed range
    output logic [1:0]       equalizer_mode,          // Equalizer mode code
    output logic             search_mode              // Auxiliary-only processing
);
    import aux_env_pkg::*;

    function automatic logic rise(input logic cur, input logic prev);
        rise = cur & ~prev;
    endfunction

    function automatic logic fall(input logic cur, input logic prev);
        fall = ~cur & prev;
    endfunction

    // Bit 7 of the address byte marks a read; both domains ask this
    function automatic logic is_read_addr(input logic [7:0] a);
        is_read_addr = a[ADDR_RD_BIT];
    endfunction

    // Register select field of an address byte
    function automatic logic [6:0] sel_field(input logic [7:0] a);
        sel_field = a[ADDR_RD_BIT-1:0];
    endfunction

    // A mode change restarts the bit count before the edge is counted
    function automatic logic [2:0] restart_count(input logic mode, input logic prev,
                                                 input logic [2:0] cnt);
        restart_count = (mode != prev) ? 3'h0 : cnt;
    endfunction

    // Serial bits enter at the bottom, so the first bit ends up as MSB
    function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b);
        shift_in = {sh[6:0], b};
    endfunction

    // Outgoing bit index: byte select on top, bit count read backwards
    function automatic logic [3:0] read_bit_pos(input logic idx, input logic [2:0] cnt);
        read_bit_pos = {idx, ~cnt};
    endfunction

    // Edge events of the three detectors, laid out as in the mask register
    function automatic logic [5:0] edge_events(input logic [3:0] cur, input logic [3:0] prv);
        edge_events               = 6'h00;
        edge_events[FLG_BLANK_UP] = rise(cur[ST1_BLANK], prv[ST1_BLANK]);
        edge_events[FLG_ENV_UP]   = rise(cur[ST1_ENV], prv[ST1_ENV]);
        edge_events[FLG_ENV_DN]   = fall(cur[ST1_ENV], prv[ST1_ENV]);
        edge_events[FLG_MARK_UP]  = rise(cur[ST1_MARK], prv[ST1_MARK]);
        edge_events[FLG_MARK_DN]  = fall(cur[ST1_MARK], prv[ST1_MARK]);
    endfunction

    // One counter step; wraps at both ends like any 16-bit counter
    function automatic logic [15:0] step_count(input logic [15:0] cnt, input logic up);
        step_count = up ? cnt + 16'h0001 : cnt - 16'h0001;
    endfunction

    // Status byte zero: bank flag, test bit, then the six recorded flags
    function automatic logic [15:0] status_zero_word(input logic bank, input logic tst,
                                                     input logic [5:0] flg);
        status_zero_word = {8'h00, bank, tst, flg};
    endfunction

    // Status byte one: live port and detector levels, upper bits zero
    function automatic logic [15:0] status_one_word(input logic [3:0] l);
        status_one_word              = WORD_ZERO;
        status_one_word[ST1_PORT_IN] = l[ST1_PORT_IN];
        status_one_word[ST1_BLANK]   = l[ST1_BLANK];
        status_one_word[ST1_ENV]     = l[ST1_ENV];
        status_one_word[ST1_MARK]    = l[ST1_MARK];
    endfunction

    // Speed word: invalid flag on top, then value and range
    function automatic logic [15:0] speed_word(input logic inv, input logic [4:0] v,
                                               input logic [1:0] r);
        speed_word = {8'h00, inv, v, r};
    endfunction

    // Set wins: an event in the clearing read cycle is kept for the next read
    function automatic logic [5:0] flag_update(input logic [5:0] flg, input logic [5:0] clr,
                                               input logic [5:0] ev, input logic [5:0] msk);
        flag_update = (flg & ~clr) | (ev & msk);
    endfunction

    // Level shown on the interrupt pin in bypass; active high
    function automatic logic bypass_level(input logic [1:0] code, input logic [3:0] l);
        case (code)
            BYP_MARKER:   bypass_level = l[ST1_MARK];
            BYP_ENVELOPE: bypass_level = l[ST1_ENV];
            BYP_BLANK:    bypass_level = l[ST1_BLANK];
            default:      bypass_level = 1'b1;
        endcase
    endfunction

    // Link side state, clocked by link_clk
    typedef struct packed {
        logic [7:0] shift;
        logic [2:0] bit_cnt;
        logic       mode_prev;
        logic [7:0] addr;
        logic       byte_idx;
        logic       req_tog;
        logic       wr_tog;
        logic [7:0] wr_byte;
        logic [7:0] wr_addr;
        logic       wr_idx;
    } link_st_t;

    // Core state, clocked by mclk
    typedef struct packed {
        logic [3:0]  lvl_s1;
        logic [3:0]  lvl_s2;
        logic [3:0]  lvl_prev;
        logic [2:0]  req_sync;
        logic [2:0]  wr_sync;
        logic [7:0]  mask;
        logic [7:0]  eq_set;
        logic [7:0]  tf_set0;
        logic [5:0]  flags;
        logic [15:0] counter;
        logic [7:0]  cnt_lo_stage;
        logic [15:0] rd_word;
        logic        int_pin;
        logic        azimuth;
    } core_st_t;

    link_st_t lk_q, lk_d;
    core_st_t c_q, c_d;

    logic [3:0] bit_pos;
    logic       link_reading;

    // Each link clock edge takes one bit. Eight bits with the mode low make
    // an address byte, eight with it high a data byte; a change of mode
    // restarts the count, so a short frame never leaks into the next one.
    // Handing a byte over flips a toggle rather than raising a pulse, since
    // the link clock may stop right after the last edge.
    // Link domain: shift in address and data bytes, MSB first
    always_comb begin
        logic [2:0] cnt;
        logic [7:0] full;
        cnt  = 3'h0;
        full = 8'h00;
        lk_d = lk_q;
        lk_d.mode_prev = link_mode;
        cnt  = restart_count(link_mode, lk_q.mode_prev, lk_q.bit_cnt);
        full = shift_in(lk_q.shift, link_data_in);
        lk_d.shift = full;
        lk_d.bit_cnt = cnt + 3'h1;
        if (cnt == LAST_BIT) begin
            if (!link_mode) begin
                lk_d.addr     = full;
                lk_d.byte_idx = 1'b0;
                lk_d.req_tog  = ~lk_q.req_tog;
            end else begin
                lk_d.byte_idx = ~lk_q.byte_idx;
                if (!is_read_addr(lk_q.addr)) begin
                    lk_d.wr_byte = full;
                    lk_d.wr_addr = lk_q.addr;
                    lk_d.wr_idx  = lk_q.byte_idx;
                    lk_d.wr_tog  = ~lk_q.wr_tog;
                end
            end
        end
        if (link_mode != lk_q.mode_prev && !link_mode) begin
            lk_d.byte_idx = 1'b0;
        end
    end

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            lk_q <= '0;
        end else begin
            lk_q <= lk_d;
        end
    end

    // The pin mux reads core flip-flops directly. That is safe only because
    // the snapshot never moves while a read frame clocks bits out; a host
    // that starts the data phase too early sees the previous word.
    // Read data: snapshot word is held steady by the core while bits leave
    assign link_reading   = link_mode & is_read_addr(lk_q.addr);
    assign bit_pos        = read_bit_pos(lk_q.byte_idx, lk_q.bit_cnt);
    assign link_data_out  = link_reading & c_q.rd_word[bit_pos];
    assign link_data_oe_n = ~link_reading;

    // Core domain. Every event is first turned into a six-bit vector in the
    // mask layout, so masking, recording and clearing are one line each.
    // A counter load beats a step in the same cycle; losing that one step
    // is the price of keeping a single adder on the counter.
    // Core domain
    always_comb begin
        logic [3:0]  lvl;
        logic [3:0]  prv;
        logic        is_search;
        logic [5:0]  events;
        logic [5:0]  clr;
        logic        step;
        logic [15:0] next_cnt;
        logic [1:0]  bypass;
        logic        req_evt;
        logic        wr_evt;
        lvl       = 4'h0;
        prv       = 4'h0;
        is_search = 1'b0;
        events    = 6'h00;
        clr       = 6'h00;
        step      = 1'b0;
        next_cnt  = CNT_RESET;
        bypass    = BYP_NONE;
        req_evt   = 1'b0;
        wr_evt    = 1'b0;
        c_d = c_q;

        // Two flops on every detector and port level before use
        c_d.lvl_s1   = {port_input, blank_tape_signal, aux_envelope, marker_level};
        c_d.lvl_s2   = c_q.lvl_s1;
        c_d.lvl_prev = c_q.lvl_s2;
        lvl = c_q.lvl_s2;
        prv = c_q.lvl_prev;

        c_d.req_sync = {c_q.req_sync[1:0], lk_q.req_tog};
        c_d.wr_sync  = {c_q.wr_sync[1:0], lk_q.wr_tog};
        req_evt = c_q.req_sync[2] ^ c_q.req_sync[1];
        wr_evt  = c_q.wr_sync[2] ^ c_q.wr_sync[1];

        is_search = (c_q.eq_set[1:0] == MODE_SEARCH);

        // Edge events against the previous sample; outside search mode the
        // detector levels mean nothing, so no event is taken from them
        if (is_search) begin
            events = edge_events(lvl, prv);
        end

        // Envelope counter; a step that lands on zero raises its own event
        step     = events[FLG_ENV_UP];
        next_cnt = step_count(c_q.counter, c_q.eq_set[EQ_DIR_BIT]);
        if (step) begin
            c_d.counter = next_cnt;
            events[FLG_CNT_ZERO] = (next_cnt == WORD_ZERO);
        end

        // Register reads: snapshot taken when the address byte lands
        // Only the flags shown in the snapshot are cleared, never later ones
        if (req_evt && is_read_addr(lk_q.addr)) begin
            case (sel_field(lk_q.addr))
                SEL_EQUALIZER_STATUS_ZERO: begin
                    c_d.rd_word = status_zero_word(coefficient_bank_switched,
                                                   status_test_bit, c_q.flags);
                    clr = c_q.flags;
                end
                SEL_EQUALIZER_STATUS_ONE: c_d.rd_word = status_one_word(lvl);
                SEL_COUNTER: c_d.rd_word = c_q.counter;
                SEL_SPEED:   c_d.rd_word = speed_word(speed_invalid_flag,
                                                      speed_value, speed_range);
                default:     c_d.rd_word = WORD_ZERO;
            endcase
        end

        // Register writes; a load beats a step in the same cycle
        // The low counter byte waits in a stage so the host never sees a
        // half-loaded counter step in between the two bytes
        if (wr_evt) begin
            case (sel_field(lk_q.wr_addr))
                SEL_MASK:    c_d.mask    = lk_q.wr_byte;
                SEL_EQ_SET:  c_d.eq_set  = lk_q.wr_byte;
                SEL_TF_SET0: c_d.tf_set0 = lk_q.wr_byte;
                SEL_COUNTER: begin
                    if (!lk_q.wr_idx) begin
                        c_d.cnt_lo_stage = lk_q.wr_byte;
                    end else begin
                        c_d.counter = {lk_q.wr_byte, c_q.cnt_lo_stage};
                    end
                end
                default: ;
            endcase
        end

        // Flags: new enabled events win over the read clear
        c_d.flags = flag_update(c_q.flags, clr, events, c_q.mask[5:0]);

        // Interrupt pin. Flags keep recording in bypass, so leaving bypass
        // with flags pending pulls the pin low at once; the host should read
        // status zero first if it wants a quiet pin.
        bypass = {c_q.mask[BYPASS_HI], c_q.mask[BYPASS_LO]};
        case (bypass)
            BYP_NONE:     c_d.int_pin = ~(|c_d.flags);
            default:      c_d.int_pin = bypass_level(bypass, lvl);
        endcase

        // Registered so the pulse is glitch free; it trails the sync by a cycle
        c_d.azimuth = tape_channel_zero | tape_channel_seven;
    end

    // Reset leaves no bypass and no flags, so the pin starts high and idle
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            c_q         <= '0;
            c_q.mask    <= MASK_RESET;
            c_q.eq_set  <= EQ_SET_RESET;
            c_q.tf_set0 <= TF_SET_RESET;
            c_q.counter <= CNT_RESET;
            c_q.int_pin <= 1'b1;
        end else begin
            c_q <= c_d;
        end
    end

    assign host_interrupt_pin = c_q.int_pin;
    assign port_output_one    = c_q.tf_set0[TF_PORT_OUT1];
    assign azimuth_check_out  = c_q.azimuth;
    assign equalizer_mode     = c_q.eq_set[1:0];
    assign search_mode        = (c_q.eq_set[1:0] == MODE_SEARCH);
endmodule
`default_nettype wire

/* tb/aux_env_sva.sv */
// Purpose: port checks of the envelope interrupt unit. Assumes: mclk domain. Notes: link as levels
`timescale 1ns/1ps
`default_nettype none
module aux_env_sva
    import aux_env_pkg::*;
(
    input wire logic       mclk, arst_n, link_clk, link_mode, link_data_out,
    input wire logic       link_data_oe_n, host_interrupt_pin, port_output_one,
    input wire logic       blank_tape_signal, aux_envelope, marker_level,
    input wire logic       tape_channel_zero, tape_channel_seven, azimuth_check_out,
    input wire logic [1:0] equalizer_mode,
    input wire logic       search_mode
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    chk_azimuth_follows: assert property (1'b1 |=>
        azimuth_check_out == $past(tape_channel_zero | tape_channel_seven)) else $error("azimuth lost");
    chk_azimuth_cause: assert property ($rose(azimuth_check_out) |->
        $past(tape_channel_zero || tape_channel_seven)) else $error("azimuth without sync");
    chk_search_decode: assert property (
        search_mode == (equalizer_mode == MODE_SEARCH)) else $error("search decode wrong");
    chk_addr_no_drive: assert property (!link_mode |-> link_data_oe_n)
        else $error("data driven in address phase");
    chk_released_low: assert property (
        link_data_oe_n && $past(link_data_oe_n, 2) |-> !link_data_out) else $error("stray data");
    chk_port_steady: assert property ((!link_mode)[*6] |-> $stable(port_output_one))
        else $error("port output moved without write");
    chk_mode_steady: assert property ((!link_mode)[*6] |->
        $stable(equalizer_mode) && $stable(search_mode)) else $error("mode moved");
    // Pin may only move on a detector change or link traffic, so quiet inputs freeze it
    chk_pin_quiet: assert property ((!link_mode && $stable(link_clk) &&
        $stable(blank_tape_signal) && $stable(aux_envelope) && $stable(marker_level))[*8]
        |-> $stable(host_interrupt_pin)) else $error("pin moved while quiet");
endmodule
bind aux_envelope_interrupt_unit aux_env_sva u_aux_env_sva (.mclk, .arst_n, .link_clk,
    .link_mode, .link_data_out, .link_data_oe_n, .host_interrupt_pin, .port_output_one,
    .blank_tape_signal, .aux_envelope, .marker_level, .tape_channel_zero,
    .tape_channel_seven, .azimuth_check_out, .equalizer_mode, .search_mode);
`default_nettype wire

/* tb/link_host.sv */
// Purpose: host side of the serial link. Assumes: 160 ns clock. Notes: clock idles low
`timescale 1ns/1ps
`default_nettype none
module link_host (
    output logic      link_clk,   // Serial clock
    output logic      link_mode,  // Low address, high data
    output logic      host_bit,   // Host level on data line
    input  wire logic line        // Resolved data line
);
    logic drive;
    initial begin
        {link_clk, link_mode, host_bit, drive} = 4'b0001;
    end
    // A released line keeps changing so a stale bit never reads as valid
    always #80 if (!drive) host_bit = ~host_bit;
    task automatic byte_io(input logic m, input logic [7:0] b, output logic [7:0] r);
        link_mode = m;
        for (int i = 7; i >= 0; i--) begin
            if (drive) host_bit = b[i];
            #80 r[i] = line;
            link_clk = 1'b1;
            #80 link_clk = 1'b0;
        end
    endtask
    task automatic xfer(input logic rd, input logic [6:0] sel, input int n,
                        input logic [15:0] wd, output logic [15:0] rw);
        logic [7:0] r;
        rw = 16'h0000;
        #7 drive = 1'b1;
        byte_io(1'b0, {rd, sel}, r);
        #400 drive = !rd;
        for (int k = 0; k < n; k++) begin
            byte_io(1'b1, wd[8*k +: 8], r);
            rw[8*k +: 8] = r;
        end
        #160 link_mode = 1'b0;
        drive = 1'b1;
        #400;
    endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
// Purpose: self-checking bench. Assumes: 40 MHz mclk. Notes: link run by u_link_host
`timescale 1ns/1ps
`default_nettype none
module tb;
    import aux_env_pkg::*;
    logic mclk, arst_n, link_clk, link_mode, host_bit, line, link_data_out, link_data_oe_n;
    logic host_interrupt_pin, blank_tape_signal, aux_envelope, marker_level, port_input;
    logic port_output_one, tape_channel_zero, tape_channel_seven, azimuth_check_out;
    logic coefficient_bank_switched, status_test_bit, speed_invalid_flag, search_mode;
    logic [4:0] speed_value;
    logic [1:0] speed_range, equalizer_mode;
    logic [15:0] rw;
    logic [2:0] sig;
    int n_errors = 0, n_compared = 0, cycles = 0;
    assign line = !link_data_oe_n ? link_data_out : host_bit;
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    link_host u_link_host (.link_clk, .link_mode, .host_bit, .line);
    aux_envelope_interrupt_unit u_aux_envelope_interrupt_unit (.mclk, .arst_n, .link_clk,
        .link_mode, .link_data_in(line), .link_data_out, .link_data_oe_n,
        .host_interrupt_pin, .blank_tape_signal, .aux_envelope, .marker_level, .port_input,
        .port_output_one, .tape_channel_zero, .tape_channel_seven, .azimuth_check_out,
        .coefficient_bank_switched, .status_test_bit, .speed_invalid_flag, .speed_value,
        .speed_range, .equalizer_mode, .search_mode);
    task automatic results;
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #2;
    endtask
    task automatic rd(input logic [6:0] sel, input int n, input logic [15:0] exp);
        u_link_host.xfer(1'b1, sel, n, 16'h0000, rw);
        chk(rw, exp);
    endtask
    task automatic wr(input logic [6:0] sel, input logic [15:0] d);
        u_link_host.xfer(1'b0, sel, (sel == SEL_COUNTER) ? 2 : 1, d, rw);
    endtask
    task automatic pin_is(input logic exp);
        for (int k = 0; k < 20 && host_interrupt_pin !== exp; k++) tick(1);
        chk(host_interrupt_pin, exp);
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            results();
        end
    end
    initial begin
        arst_n = 1'b0;
        {blank_tape_signal, aux_envelope, marker_level, port_input} = 4'h0;
        {tape_channel_zero, tape_channel_seven, coefficient_bank_switched, status_test_bit} = 4'h0;
        {speed_invalid_flag, speed_value, speed_range} = 8'hD6;
        tick(3);
        arst_n = 1'b1;
        tick(3);
        chk(host_interrupt_pin, 1'b1);
        rd(SEL_MASK, 1, 16'h0000);
        rd(7'h7F, 1, 16'h0000);
        rd(SEL_SPEED, 1, 16'h00D6);
        speed_invalid_flag = 1'b0;
        rd(SEL_SPEED, 1, 16'h0056);
        {port_input, blank_tape_signal, marker_level} = 3'h7;
        rd(SEL_EQUALIZER_STATUS_ONE, 1, 16'h000D);
        {port_input, blank_tape_signal, aux_envelope, marker_level} = 4'h2;
        rd(SEL_EQUALIZER_STATUS_ONE, 1, 16'h0002);
        aux_envelope = 1'b0;
        for (int v = 1; v >= 0; v--) begin
            wr(SEL_TF_SET0, 16'(v));
            chk(port_output_one, v[0]);
        end
        {coefficient_bank_switched, status_test_bit} = 2'h3;
        rd(SEL_EQUALIZER_STATUS_ZERO, 1, 16'h00C0);
        wr(SEL_EQ_SET, 16'h0005);
        chk(search_mode, 1'b1);
        wr(SEL_MASK, 16'h0006);
        aux_envelope = 1'b1;
        tick(10);
        chk(host_interrupt_pin, 1'b1);
        aux_envelope = 1'b0;
        marker_level = 1'b1;
        pin_is(1'b0);
        marker_level = 1'b0;
        tick(10);
        rd(SEL_EQUALIZER_STATUS_ZERO, 1, 16'h00C6);
        pin_is(1'b1);
        rd(SEL_EQUALIZER_STATUS_ZERO, 1, 16'h00C0);
        wr(SEL_MASK, 16'h0039);
        wr(SEL_COUNTER, 16'hFFFF);
        {blank_tape_signal, aux_envelope} = 2'h3;
        pin_is(1'b0);
        {blank_tape_signal, aux_envelope} = 2'h0;
        tick(10);
        rd(SEL_EQUALIZER_STATUS_ZERO, 1, 16'h00F9);
        rd(SEL_COUNTER, 2, 16'h0000);
        wr(SEL_EQ_SET, 16'h0001);
        aux_envelope = 1'b1;
        tick(10);
        aux_envelope = 1'b0;
        tick(10);
        rd(SEL_COUNTER, 2, 16'hFFFF);
        rd(SEL_EQUALIZER_STATUS_ZERO, 1, 16'h00D8);
        // Each bypass code lifts its own detector, then a second event must stay hidden
        for (int c = 1; c < 4; c++) begin
            wr(SEL_MASK, {8'h00, c[1:0], 6'h3F});
            sig = 3'b001 << (c - 1);
            {blank_tape_signal, aux_envelope, marker_level} = sig;
            pin_is(1'b1);
            {blank_tape_signal, aux_envelope, marker_level} = sig | {sig[1:0], sig[2]};
            tick(10);
            chk(host_interrupt_pin, 1'b1);
            {blank_tape_signal, aux_envelope, marker_level} = 3'h0;
            pin_is(1'b0);
        end
        wr(SEL_MASK, 16'h0000);
        for (int i = 0; i < 2; i++) begin
            {tape_channel_seven, tape_channel_zero} = 2'b01 << i;
            tick(1);
            {tape_channel_seven, tape_channel_zero} = 2'b00;
            chk(azimuth_check_out, 1'b1);
        end
        results();
    end
endmodule
`default_nettype wire
